// ===== verilog/hcp_pkg.sv
// Notes on behaviour
// - Structure word read-only at offset 0x0004
// - Bits 23:20 debug port number, zero
// - Bit 16 port indicators, not supported
// - Bits 15:12 companion count, zero
// - Bits 11:8 ports per companion, zero
// - Bit 7 port routing method, zero
// - Bit 4 port power switching, one
// - Bits 3:0 downstream ports, one
// - Capability word read-only at offset 0x0008
// - Bits 15:8 extended capability pointer, zero
// - Bits 7:4 isochronous threshold, 1000b
// - Bit 2 async park capable, one
// - Bit 1 programmable frame list, one
package hcp_pkg;
	// ---------------------------------------------
	// Register map
	// ---------------------------------------------
	localparam logic [17:0] STRUCT_OFFSET = 18'h00004;
	localparam logic [17:0] CAP_OFFSET    = 18'h00008;
	// ---------------------------------------------
	// Field positions and values
	// ---------------------------------------------
	localparam int          DEBUG_PORT_LSB    = 20;
	localparam int          INDICATOR_BIT     = 16;
	localparam int          COMPANION_LSB     = 12;
	localparam int          PER_COMP_LSB      = 8;
	localparam int          ROUTING_BIT       = 7;
	localparam int          POWER_BIT         = 4;
	localparam int          NPORTS_LSB        = 0;
	localparam int          EXT_PTR_LSB       = 8;
	localparam int          ISO_LSB           = 4;
	localparam int          PARK_BIT          = 2;
	localparam int          PROG_FL_BIT       = 1;
	localparam logic [3:0]  DEBUG_PORT_VAL    = 4'h0;
	localparam logic        INDICATOR_VAL     = 1'b0;
	localparam logic [3:0]  COMPANION_VAL     = 4'h0;
	localparam logic [3:0]  PER_COMP_VAL      = 4'h0;
	localparam logic        ROUTING_VAL       = 1'b0;
	localparam logic        POWER_VAL         = 1'b1;
	localparam logic [3:0]  NPORTS_VAL        = 4'h1;
	localparam logic [7:0]  EXT_PTR_VAL       = 8'h00;
	localparam logic [3:0]  ISO_VAL           = 4'h8;
	localparam logic        PARK_VAL          = 1'b1;
	localparam logic        PROG_FL_VAL       = 1'b1;
	localparam logic [31:0] RESET_DATA        = 32'h0000_0000;
endpackage

// ===== verilog/hcp_word_build.sv
`timescale 1ns/1ns
module hcp_word_build (
	output logic [31:0] struct_word_o,
	output logic [31:0] cap_word_o
);
	always_comb begin
		struct_word_o = 32'h0000_0000;
		struct_word_o[hcp_pkg::DEBUG_PORT_LSB +: 4] = hcp_pkg::DEBUG_PORT_VAL;
		struct_word_o[hcp_pkg::INDICATOR_BIT]       = hcp_pkg::INDICATOR_VAL;
		struct_word_o[hcp_pkg::COMPANION_LSB +: 4]  = hcp_pkg::COMPANION_VAL;
		struct_word_o[hcp_pkg::PER_COMP_LSB +: 4]   = hcp_pkg::PER_COMP_VAL;
		struct_word_o[hcp_pkg::ROUTING_BIT]         = hcp_pkg::ROUTING_VAL;
		struct_word_o[hcp_pkg::POWER_BIT]           = hcp_pkg::POWER_VAL;
		struct_word_o[hcp_pkg::NPORTS_LSB +: 4]     = hcp_pkg::NPORTS_VAL;
		cap_word_o = 32'h0000_0000;
		cap_word_o[hcp_pkg::EXT_PTR_LSB +: 8] = hcp_pkg::EXT_PTR_VAL;
		cap_word_o[hcp_pkg::ISO_LSB +: 4]     = hcp_pkg::ISO_VAL;
		cap_word_o[hcp_pkg::PARK_BIT]         = hcp_pkg::PARK_VAL;
		cap_word_o[hcp_pkg::PROG_FL_BIT]      = hcp_pkg::PROG_FL_VAL;
	end
endmodule

// ===== verilog/hcp_regs.sv
`timescale 1ns/1ns
module hcp_regs (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        clk_en_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [17:0] addr_i,
	input  wire logic [31:0] wdata_i,
	output logic      [31:0] rdata_o,
	output logic             rvalid_o
);
	// ---------------------------------------------
	// State
	// ---------------------------------------------
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_STRUCT,
		SEL_CAP
	} hcp_sel_e;

	// Sel names the word that rdata holds
	typedef struct packed {
		logic [31:0] rdata;
		logic        rvalid;
		hcp_sel_e    sel;
	} hcp_state_s;

	hcp_state_s  st;
	hcp_state_s  next_st;
	hcp_sel_e    rd_sel;
	logic [31:0] struct_word;
	logic [31:0] cap_word;

	// ---------------------------------------------
	// Fixed parameter words
	// ---------------------------------------------
	hcp_word_build hcp_word_build_i (
		.struct_word_o (struct_word),
		.cap_word_o    (cap_word)
	);

	// ---------------------------------------------
	// Address decode
	// ---------------------------------------------
	// Any other offset reads as zero
	always_comb begin
		rd_sel = SEL_NONE;
		if (addr_i == hcp_pkg::STRUCT_OFFSET) begin
			rd_sel = SEL_STRUCT;
		end else if (addr_i == hcp_pkg::CAP_OFFSET) begin
			rd_sel = SEL_CAP;
		end
	end

	// ---------------------------------------------
	// Read path; writes have no target
	// ---------------------------------------------
	always_comb begin
		next_st        = st;
		next_st.rvalid = 1'b0;
		if (rd_i) begin
			next_st.rvalid = 1'b1;
			next_st.sel    = rd_sel;
			case (rd_sel)
				SEL_STRUCT: begin
					next_st.rdata = struct_word;
				end
				SEL_CAP: begin
					next_st.rdata = cap_word;
				end
				default: begin
					next_st.rdata = hcp_pkg::RESET_DATA;
				end
			endcase
		end
	end

	// ---------------------------------------------
	// Registers
	// ---------------------------------------------
	// Reset wins over a low clock enable
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st <= '{rdata: hcp_pkg::RESET_DATA, rvalid: 1'b0, sel: SEL_NONE};
		end else if (clk_en_i) begin
			st <= next_st;
		end
	end

	assign rdata_o  = st.rdata;
	assign rvalid_o = st.rvalid;

	// ---------------------------------------------
	// Checks: reset and handshake
	// ---------------------------------------------
	reset_clear_a: assert property (@(posedge ref_clk_i)
		rst_i
		|=> rdata_o == 32'h0000_0000 && !rvalid_o)
		else $error("read port not cleared by reset");

	read_answer_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && rd_i
		|=> rvalid_o)
		else $error("read not answered in one cycle");

	sel_track_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && rd_i
		|=> st.sel == $past(rd_sel))
		else $error("held word selector wrong");

	valid_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && !rd_i
		|=> !rvalid_o)
		else $error("read valid without a read");

	hold_data_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && !rd_i
		|=> $stable(rdata_o))
		else $error("read data changed without a read");

	enable_freeze_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!clk_en_i
		|=> $stable(rdata_o) && $stable(rvalid_o))
		else $error("state moved with clock enable low");

	write_ignored_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && wr_i && !rd_i
		|=> $stable(rdata_o) && !rvalid_o)
		else $error("write changed read data");

	unmapped_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && rd_i && rd_sel == SEL_NONE
		|=> rdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	// ---------------------------------------------
	// Checks: whole words
	// ---------------------------------------------
	build_struct_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		struct_word == 32'h0000_0011)
		else $error("structure word build wrong");

	build_cap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		cap_word == 32'h0000_0086)
		else $error("capability word build wrong");

	struct_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && rd_i && addr_i == hcp_pkg::STRUCT_OFFSET
		|=> rdata_o == 32'h0000_0011 && rvalid_o)
		else $error("structure word wrong");

	cap_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		clk_en_i && rd_i && addr_i == hcp_pkg::CAP_OFFSET
		|=> rdata_o == 32'h0000_0086 && rvalid_o)
		else $error("capability word wrong");

	// ---------------------------------------------
	// Checks: structure word fields
	// ---------------------------------------------
	debug_port_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_STRUCT
		|-> rdata_o[23:20] == 4'h0)
		else $error("debug port number not zero");

	port_indicator_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_STRUCT
		|-> rdata_o[16] == 1'b0)
		else $error("port indicator bit set");

	companion_count_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_STRUCT
		|-> rdata_o[15:12] == 4'h0)
		else $error("companion count not zero");

	per_companion_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_STRUCT
		|-> rdata_o[11:8] == 4'h0)
		else $error("ports per companion not zero");

	port_routing_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_STRUCT
		|-> rdata_o[7] == 1'b0)
		else $error("port routing bit set");

	port_power_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_STRUCT
		|-> rdata_o[4] == 1'b1)
		else $error("port power switching bit clear");

	port_count_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_STRUCT
		|-> rdata_o[3:0] == 4'h1)
		else $error("downstream port count not one");

	struct_reserved_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_STRUCT
		|-> rdata_o[31:24] == 8'h00 && rdata_o[19:17] == 3'h0 && rdata_o[6:5] == 2'h0)
		else $error("structure reserved bits set");

	// ---------------------------------------------
	// Checks: capability word fields
	// ---------------------------------------------
	ext_pointer_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_CAP
		|-> rdata_o[15:8] == 8'h00)
		else $error("extended capability pointer not zero");

	iso_threshold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_CAP
		|-> rdata_o[7:4] == 4'h8)
		else $error("isochronous threshold wrong");

	async_park_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_CAP
		|-> rdata_o[2] == 1'b1)
		else $error("async park bit clear");

	frame_list_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_CAP
		|-> rdata_o[1] == 1'b1)
		else $error("programmable frame list bit clear");

	cap_reserved_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		st.sel == SEL_CAP
		|-> rdata_o[31:16] == 16'h0000 && rdata_o[3] == 1'b0 && rdata_o[0] == 1'b0)
		else $error("capability reserved bits set");
endmodule

// ===== verif/tb_host_capability_params.sv
`timescale 1ns/1ns
module tb_host_capability_params;
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        clk_en_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        wr_i = 1'b0;
	logic [17:0] addr_i = 18'h00000;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic [31:0] rdata_o;
	logic        rvalid_o;
	logic [31:0] last = 32'h0000_0000;
	logic        vlast = 1'b0;
	logic [15:0] r = 16'h0060;
	int          errors = 0;
	int          check_count = 0;
	int          cycles = 0;

	hcp_regs hcp_regs_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
		.rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o));

	function automatic logic [15:0] lfsr(logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [31:0] exp_word(logic [17:0] a);
		if (a == 18'h00004) return 32'h0000_0011;
		if (a == 18'h00008) return 32'h0000_0086;
		return 32'h0000_0000;
	endfunction

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want) begin
			errors++;
			$display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
		end
	endtask

	task automatic cmp_flag(input logic got, input logic want);
		check_count++;
		if (got !== want) begin
			errors++;
			$display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
		end
	endtask

	task automatic access(input logic en, input logic rd, input logic wr, input logic [17:0] a);
		clk_en_i = en;
		rd_i = rd;
		wr_i = wr;
		addr_i = a;
		wdata_i = {r, ~r} & 32'h0000_ff96;
		@(posedge ref_clk_i);
		#5;
		if (rst_i) begin
			vlast = 1'b0;
			last = 32'h0000_0000;
		end else if (en) begin
			vlast = rd;
			if (rd) last = exp_word(a);
		end
		cmp_flag(rvalid_o, vlast);
		cmp_word(rdata_o, last);
	endtask

	task print_verdict;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial forever #50 ref_clk_i = ~ref_clk_i;

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 1000) begin
			errors++;
			print_verdict;
		end
	end

	initial begin
		repeat (6) @(posedge ref_clk_i);
		#5;
		rst_i = 1'b0;
		access(1'b1, 1'b1, 1'b0, 18'h00004);
		access(1'b1, 1'b1, 1'b0, 18'h00008);
		cmp_flag(rdata_o[1], 1'b1);
		access(1'b1, 1'b0, 1'b1, 18'h00004);
		access(1'b1, 1'b1, 1'b1, 18'h00004);
		access(1'b0, 1'b1, 1'b0, 18'h00008);
		access(1'b1, 1'b1, 1'b0, 18'h00010);
		access(1'b1, 1'b1, 1'b0, 18'h00008);
		rst_i = 1'b1;
		access(1'b1, 1'b1, 1'b0, 18'h00008);
		rst_i = 1'b0;
		for (int i = 0; i < 300; i++) begin
			r = lfsr(r);
			access(r[0] | r[6], r[1] | r[2], r[3], r[4] ? (r[5] ? 18'h00008 : 18'h00004)
				: {r, r[2:1]});
		end
		print_verdict;
	end
endmodule
